// ### hw/rtcalm_pkg.sv
// package: register map, fields and types of the alarm repeat control
package rtcalm_pkg;

  // register byte offsets
  localparam logic [11:0] RTCALM_OFS_CTRL   = 12'h000;
  localparam logic [11:0] RTCALM_OFS_ISTAT  = 12'h004;
  localparam logic [11:0] RTCALM_OFS_IMASK  = 12'h008;

  // alarm control field positions
  localparam int RTCALM_BIT_ENABLE   = 15;
  localparam int RTCALM_BIT_WRAP     = 14;
  localparam int RTCALM_BIT_PIV      = 13;
  localparam int RTCALM_BIT_ROLLWARN = 12;
  localparam int RTCALM_SEL_HI       = 11;
  localparam int RTCALM_SEL_LO       = 8;
  localparam int RTCALM_CNT_HI       = 7;
  localparam int RTCALM_CNT_LO       = 0;

  // interrupt status and mask field positions
  localparam int RTCALM_IRQ_ALARM    = 0;
  localparam int RTCALM_IRQ_STOP     = 1;
  localparam int RTCALM_IRQ_W        = 2;

  // reset values and repeat counter constants
  localparam logic [7:0] RTCALM_CNT_RST  = 8'h00;
  localparam logic [3:0] RTCALM_SEL_RST  = 4'h0;
  localparam logic [7:0] RTCALM_CNT_ZERO = 8'h00;
  localparam logic [7:0] RTCALM_CNT_TOP  = 8'hFF;
  localparam logic [7:0] RTCALM_CNT_ONE  = 8'h01;
  localparam logic [RTCALM_IRQ_W-1:0] RTCALM_IRQ_RST = 2'h0;

  // synchroniser width: tick toggle, near flag, eight match flags
  localparam int RTCALM_SYNC_W = 10;

  // edges after reset before the tick edge detector is trusted
  localparam logic [1:0] RTCALM_FILL_ZERO = 2'h0;
  localparam logic [1:0] RTCALM_FILL_ONE  = 2'h1;
  localparam logic [1:0] RTCALM_FILL_DONE = 2'h3;

  // interval select codes
  typedef enum logic [3:0] {
    RTCALM_IV_HALFSEC = 4'h0,
    RTCALM_IV_SEC     = 4'h1,
    RTCALM_IV_TENSEC  = 4'h2,
    RTCALM_IV_MIN     = 4'h3,
    RTCALM_IV_TENMIN  = 4'h4,
    RTCALM_IV_HOUR    = 4'h5,
    RTCALM_IV_DAY     = 4'h6,
    RTCALM_IV_WEEK    = 4'h7,
    RTCALM_IV_MONTH   = 4'h8,
    RTCALM_IV_YEAR    = 4'h9
  } rtcalm_interval_type;

  // per-field equality of calendar time against alarm time
  typedef struct packed {
    logic month;
    logic day;
    logic wday;
    logic hour;
    logic min_tens;
    logic min_ones;
    logic sec_tens;
    logic sec_ones;
  } rtcalm_match_type;

  // software view of the control register
  typedef struct packed {
    logic       alarm_enable_bit;
    logic       repeat_wrap;
    logic       pulse_initial_value;
    logic [3:0] alarm_interval_select;
    logic [7:0] alarm_repeat_count;
  } rtcalm_ctrl_type;

endpackage : rtcalm_pkg

// ### hw/rtcalm_sync.sv
// two-flop synchroniser for a bundle of slow single-bit levels
`timescale 1ns/10ps
`default_nettype none
module rtcalm_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // levels in and out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_r;

  // first stage feeds only the second
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        stage1_r[i] <= 1'b0;
        sync_out[i] <= 1'b0;
      end
      else
      begin
        stage1_r[i] <= async_in[i];
        sync_out[i] <= stage1_r[i];
      end
    end
  end

endmodule : rtcalm_sync
`default_nettype wire

// ### hw/rtcalm_top.sv
// alarm enable, interval select and repeat counter with apb registers
//
// How it works
// - alarm events occur only while the enable bit 15 is set
// - wrap set: repeat count rolls from 0x00 to 0xFF and goes on
// - wrap clear: repeat count holds at 0x00 once reached
// - bit 13 writable while disabled; read-only pulse level while enabled
// - warning bit 12 reads zero only when rollover is over 32 clocks away
// - interval select picks half-second up to yearly alarm period
// - yearly alarm on February 29 fires once every four years
// - event at count 00 with wrap clear clears the enable bit
// - control register resets on power-on only, all fields zero
// - repeat count in bits 7..0, interval select in bits 11..8
`timescale 1ns/10ps
`default_nettype none
module rtcalm_top (
  // clock and power-on reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // other reset sources, same clock
  input  wire logic                      sys_reset,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // from the rtc timekeeping, asynchronous
  input  wire logic                      rtc_half_sec_toggle,
  input  wire logic                      rtc_rollover_near,
  input  wire rtcalm_pkg::rtcalm_match_type rtc_match,
  // alarm outputs
  output logic                           alarm_pulse,
  output logic                           alarm_event,
  output logic                           irq
);
  import rtcalm_pkg::*;

  logic [RTCALM_SYNC_W-1:0] sync_in;
  logic [RTCALM_SYNC_W-1:0] sync_q;
  logic                     tick_s;
  logic                     tick_d_r;
  logic [1:0]               fill_r;
  logic                     near_s;
  rtcalm_match_type         match_s;
  logic                     half_phase_r;
  logic                     half_tick;
  logic                     whole_tick;
  logic                     match_hit;
  logic                     fire;

  rtcalm_ctrl_type          ctrl_r;
  logic                     pulse_r;
  logic [RTCALM_IRQ_W-1:0]  istat_r;
  logic [RTCALM_IRQ_W-1:0]  imask_r;
  logic [RTCALM_IRQ_W-1:0]  irq_set;
  logic                     event_r;

  logic                     wr_en;
  logic                     rd_en;
  logic                     hit_ctrl;
  logic                     hit_istat;
  logic                     hit_imask;
  logic                     addr_ok;
  logic                     stop_evt;
  logic [31:0]              rdata_nxt;
  logic [31:0]              ctrl_view;

  // rtc-side levels through two flops
  // match flags must stand a few clocks around each tick
  assign sync_in = {rtc_match, rtc_rollover_near, rtc_half_sec_toggle};

  rtcalm_sync #(
    .WIDTH (RTCALM_SYNC_W)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (sync_in),
    .sync_out (sync_q)
  );

  // field flags are levels; only the tick needs an edge
  assign tick_s  = sync_q[0];
  assign near_s  = sync_q[1];
  assign match_s = rtcalm_match_type'(sync_q[RTCALM_SYNC_W-1:2]);

  // half-second tick from the synchronised toggle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_d_r <= 1'b0;
    else
      tick_d_r <= tick_s;
  end

  // a toggle pin resting high would look like a tick right after reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fill_r <= RTCALM_FILL_ZERO;
    else if (fill_r != RTCALM_FILL_DONE)
      fill_r <= fill_r + RTCALM_FILL_ONE;
  end

  assign half_tick = (tick_s ^ tick_d_r)
                     && (fill_r == RTCALM_FILL_DONE);

  // which half of the second we are in; whole second on the half tick taken while the phase is set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      half_phase_r <= 1'b0;
    else if (half_tick)
      half_phase_r <= ~half_phase_r;
  end

  // phase starts at reset, not at a calendar second boundary
  assign whole_tick = half_tick && half_phase_r;

  // interval select chooses the calendar fields that must agree
  always_comb
  begin
    match_hit = 1'b0;
    case (rtcalm_interval_type'(ctrl_r.alarm_interval_select))
      RTCALM_IV_HALFSEC: match_hit = half_tick;
      RTCALM_IV_SEC:     match_hit = whole_tick;
      RTCALM_IV_TENSEC:  match_hit = whole_tick && match_s.sec_ones;
      RTCALM_IV_MIN:     match_hit = whole_tick && match_s.sec_ones
                                     && match_s.sec_tens;
      RTCALM_IV_TENMIN:  match_hit = whole_tick && match_s.sec_ones
                                     && match_s.sec_tens
                                     && match_s.min_ones;
      RTCALM_IV_HOUR:    match_hit = whole_tick && match_s.sec_ones
                                     && match_s.sec_tens
                                     && match_s.min_ones
                                     && match_s.min_tens;
      RTCALM_IV_DAY:     match_hit = whole_tick && match_s.sec_ones
                                     && match_s.sec_tens
                                     && match_s.min_ones
                                     && match_s.min_tens
                                     && match_s.hour;
      RTCALM_IV_WEEK:    match_hit = whole_tick && match_s.sec_ones
                                     && match_s.sec_tens
                                     && match_s.min_ones
                                     && match_s.min_tens
                                     && match_s.hour && match_s.wday;
      RTCALM_IV_MONTH:   match_hit = whole_tick && match_s.sec_ones
                                     && match_s.sec_tens
                                     && match_s.min_ones
                                     && match_s.min_tens
                                     && match_s.hour && match_s.day;
      // full date compare: a feb 29 date exists only in leap years
      RTCALM_IV_YEAR:    match_hit = whole_tick && match_s.sec_ones
                                     && match_s.sec_tens
                                     && match_s.min_ones
                                     && match_s.min_tens
                                     && match_s.hour && match_s.day
                                     && match_s.month;
      // reserved codes never match
      default:           match_hit = 1'b0;
    endcase
  end

  assign fire     = match_hit && ctrl_r.alarm_enable_bit;
  assign stop_evt = fire && !ctrl_r.repeat_wrap
                    && (ctrl_r.alarm_repeat_count == RTCALM_CNT_ZERO);

  // apb decode; zero wait states
  // reads finish in two bus clocks, inside the warning margin
  assign wr_en     = psel && penable && pwrite;
  assign rd_en     = psel && !penable && !pwrite;
  assign hit_ctrl  = (paddr == RTCALM_OFS_CTRL);
  assign hit_istat = (paddr == RTCALM_OFS_ISTAT);
  assign hit_imask = (paddr == RTCALM_OFS_IMASK);
  assign addr_ok   = hit_ctrl || hit_istat || hit_imask;
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !addr_ok;

  // alarm enable: write, or cleared when the last repeat fires
  // auto-stop beats a same-cycle software write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r.alarm_enable_bit <= 1'b0;
    else if (stop_evt)
      ctrl_r.alarm_enable_bit <= 1'b0;
    else if (wr_en && hit_ctrl)
      ctrl_r.alarm_enable_bit <= pwdata[RTCALM_BIT_ENABLE];
  end

  // wrap and interval select: plain software fields
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r.repeat_wrap           <= 1'b0;
      ctrl_r.alarm_interval_select <= RTCALM_SEL_RST;
    end
    else if (wr_en && hit_ctrl)
    begin
      ctrl_r.repeat_wrap           <= pwdata[RTCALM_BIT_WRAP];
      ctrl_r.alarm_interval_select <=
        pwdata[RTCALM_SEL_HI:RTCALM_SEL_LO];
    end
  end

  // stored initial value of the pulse, writable only while disabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r.pulse_initial_value <= 1'b0;
    else if (wr_en && hit_ctrl && !ctrl_r.alarm_enable_bit)
      ctrl_r.pulse_initial_value <= pwdata[RTCALM_BIT_PIV];
  end

  // repeat counter: counts down per event, wrap or hold at zero
  // a write landing with an event is dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r.alarm_repeat_count <= RTCALM_CNT_RST;
    else if (fire)
    begin
      if (ctrl_r.alarm_repeat_count != RTCALM_CNT_ZERO)
        ctrl_r.alarm_repeat_count <=
          ctrl_r.alarm_repeat_count - RTCALM_CNT_ONE;
      else if (ctrl_r.repeat_wrap)
        ctrl_r.alarm_repeat_count <= RTCALM_CNT_TOP;
      else
        ctrl_r.alarm_repeat_count <= RTCALM_CNT_ZERO;
    end
    else if (wr_en && hit_ctrl)
      ctrl_r.alarm_repeat_count <=
        pwdata[RTCALM_CNT_HI:RTCALM_CNT_LO];
  end

  // alarm pulse: follows the initial value while disabled, toggles per event
  // disabled: a written initial value shows on the pin at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pulse_r <= 1'b0;
    else if (fire)
      pulse_r <= ~pulse_r;
    else if (!ctrl_r.alarm_enable_bit)
    begin
      if (wr_en && hit_ctrl)
        pulse_r <= pwdata[RTCALM_BIT_PIV];
      else
        pulse_r <= ctrl_r.pulse_initial_value;
    end
  end

  // one-cycle alarm event output
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      event_r <= 1'b0;
    else
      event_r <= fire;
  end

  assign alarm_event = event_r;
  assign alarm_pulse = pulse_r;

  // interrupt status: set wins over write-one-to-clear
  // sys_reset keeps only the sets of its own cycle
  assign irq_set = {stop_evt, fire};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      istat_r <= RTCALM_IRQ_RST;
    else if (sys_reset)
      istat_r <= irq_set;
    else if (wr_en && hit_istat)
      istat_r <= (istat_r & ~pwdata[RTCALM_IRQ_W-1:0]) | irq_set;
    else
      istat_r <= istat_r | irq_set;
  end

  // interrupt mask; other resets clear it, control register untouched
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      imask_r <= RTCALM_IRQ_RST;
    else if (sys_reset)
      imask_r <= RTCALM_IRQ_RST;
    else if (wr_en && hit_imask)
      imask_r <= pwdata[RTCALM_IRQ_W-1:0];
  end

  assign irq = |(istat_r & imask_r);

  // read view of the control register
  // bit 12 is read-only; writes to it are dropped
  always_comb
  begin
    ctrl_view = 32'h0000_0000;
    ctrl_view[RTCALM_BIT_ENABLE] = ctrl_r.alarm_enable_bit;
    ctrl_view[RTCALM_BIT_WRAP]   = ctrl_r.repeat_wrap;
    ctrl_view[RTCALM_BIT_PIV]    = ctrl_r.alarm_enable_bit
                                   ? pulse_r
                                   : ctrl_r.pulse_initial_value;
    ctrl_view[RTCALM_BIT_ROLLWARN] = near_s;
    ctrl_view[RTCALM_SEL_HI:RTCALM_SEL_LO] = ctrl_r.alarm_interval_select;
    ctrl_view[RTCALM_CNT_HI:RTCALM_CNT_LO] = ctrl_r.alarm_repeat_count;
  end

  // read data mux
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (hit_ctrl)
      rdata_nxt = ctrl_view;
    else if (hit_istat)
      rdata_nxt[RTCALM_IRQ_W-1:0] = istat_r;
    else if (hit_imask)
      rdata_nxt[RTCALM_IRQ_W-1:0] = imask_r;
  end

  // read data captured in the setup cycle, held through the access
  // a same-cycle event cannot tear a read in progress
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_en)
      prdata <= rdata_nxt;
  end

endmodule : rtcalm_top
`default_nettype wire

// ### testbench/rtcalm_props.sv
// checker for the alarm repeat control ports
`timescale 1ns/10ps
`default_nettype none
module rtcalm_props
  import rtcalm_pkg::*;
(
  // clock and power-on reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // rtc side and alarm
  input wire logic        rtc_rollover_near,
  input wire logic        alarm_event
);
  logic       mapped;
  logic       en_sw_r;
  logic [2:0] gap_r;
  assign mapped = paddr == RTCALM_OFS_CTRL || paddr == RTCALM_OFS_ISTAT
    || paddr == RTCALM_OFS_IMASK;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // enable as last written by software
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      en_sw_r <= 1'b0;
    else if (psel && penable && pwrite && paddr == RTCALM_OFS_CTRL)
      en_sw_r <= pwdata[RTCALM_BIT_ENABLE];
  // cycles since enable was last seen, covers the event pipeline
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      gap_r <= 3'h7;
    else if (en_sw_r)
      gap_r <= 3'h0;
    else if (gap_r != 3'h7)
      gap_r <= gap_r + 3'h1;
  sequence rd_setup;
    psel && !penable && !pwrite;
  endsequence
  sequence near_hi;
    rtc_rollover_near [*3];
  endsequence
  sequence near_lo;
    !rtc_rollover_near [*3];
  endsequence
  chk_event_single:
    assert property (alarm_event |=> !alarm_event)
    else $error("alarm event longer than one cycle");
  chk_event_enabled:
    assert property (alarm_event |-> en_sw_r || gap_r < 3'h4)
    else $error("alarm event while disabled");
  chk_unmapped_err:
    assert property (psel && penable && !mapped |-> pslverr)
    else $error("no error on unmapped access");
  chk_unmapped_zero:
    assert property (rd_setup ##0 !mapped |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_upper_zero:
    assert property (rd_setup |=> prdata[31:16] == 16'h0)
    else $error("reserved read bits not zero");
  chk_rdata_stands:
    assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed without a read");
  chk_warn_set:
    assert property (near_hi ##0 rd_setup ##0 paddr == RTCALM_OFS_CTRL
      |=> prdata[RTCALM_BIT_ROLLWARN])
    else $error("warning flag missing near rollover");
  chk_warn_clear:
    assert property (near_lo ##0 rd_setup ##0 paddr == RTCALM_OFS_CTRL
      |=> !prdata[RTCALM_BIT_ROLLWARN])
    else $error("warning flag set far from rollover");
endmodule : rtcalm_props
bind rtcalm_top rtcalm_props u_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pslverr, .rtc_rollover_near,
  .alarm_event);
`default_nettype wire

// ### testbench/tb_rtcalm_top.sv
// self-checking bench for the alarm repeat control
`timescale 1ns/10ps
`default_nettype none
module tb_rtcalm_top;
  import rtcalm_pkg::*;
  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  logic             sys_reset = 1'b0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [11:0]      paddr = 12'h000;
  logic [31:0]      pwdata = 32'h0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             rtc_half_sec_toggle = 1'b0;
  logic             rtc_rollover_near = 1'b0;
  rtcalm_match_type rtc_match = 8'h00;
  logic             alarm_pulse;
  logic             alarm_event;
  logic             irq;
  logic [31:0]      rd;
  logic             err;
  logic [31:0]      v;
  logic [31:0]      e;
  int               seed = 93442;
  int               n_mismatch = 0;
  int               checks_done = 0;
  int               n_ev = 0;
  int               e0;
  int               cyc = 0;

  rtcalm_top u_dut (.pclk, .presetn, .sys_reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rtc_half_sec_toggle,
    .rtc_rollover_near, .rtc_match, .alarm_pulse, .alarm_event, .irq);

  always #12.5 pclk = ~pclk;

  function automatic logic [31:0] word(input logic en, wr, pv,
    input logic [3:0] sel, input logic [7:0] cnt);
    return {16'h0, en, wr, pv, 1'b0, sel, cnt};
  endfunction : word

  // events expected over two ticks for an interval code
  function automatic logic [31:0] exp_ev(input logic [3:0] c, input logic m);
    if (c == RTCALM_IV_HALFSEC)
      return 32'h2;
    return (c == RTCALM_IV_SEC || m) ? 32'h1 : 32'h0;
  endfunction : exp_ev

  task automatic give_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task automatic tick();
    rtc_half_sec_toggle <= ~rtc_half_sec_toggle;
    repeat (8) @(posedge pclk);
  endtask : tick

  always @(posedge pclk)
  begin
    cyc++;
    if (alarm_event === 1'b1)
      n_ev++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(RTCALM_OFS_CTRL, 32'h0);
    rdc(RTCALM_OFS_ISTAT, 32'h0);
    chk({31'h0, err}, 32'h0);
    rdc(12'h00C, 32'h0);
    chk({31'h0, err}, 32'h1);
    repeat (4)
    begin
      v = $random(seed);
      v[11:8] = v[11:8] % 4'hA;
      e = word(1'b0, v[14], 1'b0, v[11:8], v[7:0]);
      apb(1'b1, RTCALM_OFS_CTRL, e | {v[31:16], 16'h1000});
      rdc(RTCALM_OFS_CTRL, e);
    end
    sys_reset <= 1'b1;
    @(posedge pclk);
    sys_reset <= 1'b0;
    rdc(RTCALM_OFS_CTRL, e);
    apb(1'b1, RTCALM_OFS_CTRL, word(1'b0, 1'b0, 1'b1, 4'h0, 8'h01));
    chk({31'h0, alarm_pulse}, 32'h1);
    apb(1'b1, RTCALM_OFS_IMASK, 32'h3);
    apb(1'b1, RTCALM_OFS_CTRL, word(1'b1, 1'b0, 1'b1, 4'h0, 8'h01));
    apb(1'b1, RTCALM_OFS_CTRL, word(1'b1, 1'b0, 1'b0, 4'h0, 8'h01));
    rdc(RTCALM_OFS_CTRL, word(1'b1, 1'b0, 1'b1, 4'h0, 8'h01));
    e0 = n_ev;
    tick();
    chk(32'(n_ev - e0), 32'h1);
    chk({31'h0, alarm_pulse}, 32'h0);
    rdc(RTCALM_OFS_CTRL, word(1'b1, 1'b0, 1'b0, 4'h0, 8'h00));
    tick();
    rdc(RTCALM_OFS_CTRL, word(1'b0, 1'b0, 1'b1, 4'h0, 8'h00));
    rdc(RTCALM_OFS_ISTAT, 32'h3);
    chk({31'h0, irq}, 32'h1);
    e0 = n_ev;
    tick();
    chk(32'(n_ev - e0), 32'h0);
    apb(1'b1, RTCALM_OFS_ISTAT, 32'h3);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, RTCALM_OFS_IMASK, 32'h0);
    apb(1'b1, RTCALM_OFS_CTRL, word(1'b1, 1'b1, 1'b1, 4'h0, 8'h00));
    tick();
    rdc(RTCALM_OFS_CTRL, word(1'b1, 1'b1, 1'b0, 4'h0, 8'hFF));
    rdc(RTCALM_OFS_ISTAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    for (int c = 0; c < 10; c++)
    begin
      rtc_match <= 8'hFF;
      apb(1'b1, RTCALM_OFS_CTRL, word(1'b0, 1'b1, 1'b0, 4'(c), 8'h00));
      apb(1'b1, RTCALM_OFS_CTRL, word(1'b1, 1'b1, 1'b0, 4'(c), 8'h00));
      e0 = n_ev;
      repeat (2) tick();
      chk(32'(n_ev - e0), exp_ev(4'(c), 1'b1));
      rtc_match <= 8'h00;
      e0 = n_ev;
      repeat (2) tick();
      chk(32'(n_ev - e0), exp_ev(4'(c), 1'b0));
    end
    // mid-run power-on reset with the toggle pin resting high
    presetn <= 1'b0;
    rtc_half_sec_toggle <= 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(RTCALM_OFS_CTRL, 32'h0);
    apb(1'b1, RTCALM_OFS_CTRL, word(1'b1, 1'b1, 1'b0, 4'h1, 8'h05));
    e0 = n_ev;
    tick();
    chk(32'(n_ev - e0), 32'h0);
    tick();
    chk(32'(n_ev - e0), 32'h1);
    rdc(RTCALM_OFS_CTRL, word(1'b1, 1'b1, 1'b1, 4'h1, 8'h04));
    rtc_rollover_near <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, RTCALM_OFS_CTRL, 32'h0);
    chk({31'h0, rd[12]}, 32'h1);
    v = rd;
    apb(1'b0, RTCALM_OFS_CTRL, 32'h0);
    chk(rd, v);
    rtc_rollover_near <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, RTCALM_OFS_CTRL, 32'h0);
    chk({31'h0, rd[12]}, 32'h0);
    give_verdict();
  end
endmodule : tb_rtcalm_top
`default_nettype wire
